//--- tmsrc_cfg.svh
// register map, field positions, reset values and sizes of the source select
`ifndef TMSRC_CFG_SVH
`define TMSRC_CFG_SVH

// register byte offsets on the bus
`define TMSRC_OFS_START     8'h00
`define TMSRC_OFS_STOP      8'h04
`define TMSRC_OFS_CLEAR     8'h08
`define TMSRC_OFS_COUNT     8'h0C
`define TMSRC_OFS_STATUS    8'h10

// reset value of every source select register
`define TMSRC_SEL_RESET     16'h0000
// number of implemented low bits in a source select register
`define TMSRC_SEL_W         16

// field positions inside a source select register
`define TMSRC_TRIG_LSB      0
`define TMSRC_PIN_LSB       8
`define TMSRC_FIELD_W       2
`define TMSRC_NUM_TRIG      4

// pin field slots: a rise / a fall (b level), b rise / b fall (a level)
`define TMSRC_SLOT_AR       0
`define TMSRC_SLOT_AF       1
`define TMSRC_SLOT_BR       2
`define TMSRC_SLOT_BF       3

// synchroniser depth in front of the edge detector
`define TMSRC_SYNC_STAGES   2

// status register bit holding the running flag
`define TMSRC_STAT_RUN      0

`endif

//--- tmsrc_pkg.sv
// types shared by the timer hardware source select block
package tmsrc_pkg;

  // counter run state
  typedef enum logic {
    TMSRC_STOPPED,
    TMSRC_COUNTING
  } tmsrc_run_e;

  // one source select register's implemented bits
  typedef logic [15:0] tmsrc_sel_t;

  // edge and level view of the six synchronised inputs
  typedef struct packed {
    logic [5:0] rise;
    logic [5:0] fall;
    logic [5:0] lvl;
  } tmsrc_edges_s;

endpackage

//--- tmsrc_top.sv
// timer counter with start, stop and clear hardware source selection
// Behaviour
// - start field 1:0 selects trigger-a edge
// - fields 3:2,5:4,7:6 select further trigger edges
// - start field 9:8: pin-a rise qualified by b
// - fields 11:10,13:12,15:14 other pin-edge combinations
// - stop field 1:0 selects trigger-a edge
// - stop field 9:8: pin-a rise qualified by b
// - clear field 1:0 selects trigger-a edge
// - clear field 9:8: pin-a rise qualified by b
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tmsrc_cfg.svh"

module tmsrc_top
  import tmsrc_pkg::*;
#(
  parameter int CNT_W  = 32,
  parameter int ADDR_W = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [3:0]        external_trigger_input,
  input  wire logic              channel_pin_a,
  input  wire logic              channel_pin_b,
  output logic      [CNT_W-1:0]  count_value,
  output logic                   count_running
);

  // input vector: triggers in 3:0, pin a in 4, pin b in 5
  localparam int NIN = 6;
  localparam int PA  = 4;
  localparam int PB  = 5;

  // evaluate all eight fields of one select register against the edges
  function automatic logic sel_hit(input tmsrc_sel_t sel,
                                   input tmsrc_edges_s e);
    logic       hit;
    logic [1:0] code;
    logic [3:0] edg;
    logic [3:0] qual;
    hit  = 1'b0;
    // trigger fields: bit 0 rising, bit 1 falling, both set is either edge
    for (int i = 0; i < `TMSRC_NUM_TRIG; i++) begin
      code = sel[`TMSRC_TRIG_LSB + i*`TMSRC_FIELD_W +: `TMSRC_FIELD_W];
      hit  = hit | (code[0] & e.rise[i]) | (code[1] & e.fall[i]);
    end
    // pin fields: edge of one pin, qualified by the level of the other
    edg[`TMSRC_SLOT_AR]  = e.rise[PA];
    edg[`TMSRC_SLOT_AF]  = e.fall[PA];
    edg[`TMSRC_SLOT_BR]  = e.rise[PB];
    edg[`TMSRC_SLOT_BF]  = e.fall[PB];
    qual[`TMSRC_SLOT_AR] = e.lvl[PB];
    qual[`TMSRC_SLOT_AF] = e.lvl[PB];
    qual[`TMSRC_SLOT_BR] = e.lvl[PA];
    qual[`TMSRC_SLOT_BF] = e.lvl[PA];
    for (int j = 0; j < 4; j++) begin
      code = sel[`TMSRC_PIN_LSB + j*`TMSRC_FIELD_W +: `TMSRC_FIELD_W];
      // 01 other pin low, 10 other pin high, 11 regardless
      hit  = hit | (edg[j] & ((code[0] & ~qual[j]) |
                              (code[1] &  qual[j])));
    end
    return hit;
  endfunction

  // input synchroniser and edge detector; the pins run free of the
  // clock, so they pass two flops before anything decodes them
  logic [NIN-1:0] sync_meta;  // first stage, only feeds sync_stab
  logic [NIN-1:0] sync_stab;  // second stage, safe to use
  logic [NIN-1:0] sync_prev;  // previous stable sample for edges
  logic [NIN-1:0] raw_in;     // gathered pins
  tmsrc_edges_s   edges;      // edges and levels for decoding

  assign raw_in = {channel_pin_b, channel_pin_a, external_trigger_input};

  // three plain shift stages; reset to low so no edge fires at release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_meta <= '0;
      sync_stab <= '0;
      sync_prev <= '0;
    end else begin
      sync_meta <= raw_in;
      sync_stab <= sync_meta;
      sync_prev <= sync_stab;
    end
  end

  // b level is taken from the same stable sample as the a edge
  always_comb begin
    edges.rise = sync_stab & ~sync_prev;
    edges.fall = ~sync_stab & sync_prev;
    edges.lvl  = sync_stab;
  end

  // bus slave: address phase captured, data phase acts
  // writes land at the end of their data phase, reads need no wait
  tmsrc_sel_t        sel_start;     // start source select
  tmsrc_sel_t        sel_stop;      // stop source select
  tmsrc_sel_t        sel_clear;     // clear source select
  tmsrc_sel_t        next_start;
  tmsrc_sel_t        next_stop;
  tmsrc_sel_t        next_clear;
  logic              wr_pend;       // write waiting for its data phase
  logic [ADDR_W-1:0] wr_addr;       // address of that write
  logic              next_wr_pend;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0]       next_rdata;
  logic              addr_ok;       // valid transfer in address phase

  // htrans bit 1 marks NONSEQ or SEQ; IDLE and BUSY are ignored
  assign addr_ok = hsel & hready & htrans[1];

  // next register contents, write capture and read data
  always_comb begin
    next_start   = sel_start;
    next_stop    = sel_stop;
    next_clear   = sel_clear;
    next_wr_pend = addr_ok & hwrite;
    next_wr_addr = haddr;
    next_rdata   = hrdata;
    // data phase of a write: unmapped offsets are dropped silently
    if (wr_pend) begin
      case (wr_addr)
        `TMSRC_OFS_START: next_start = hwdata[`TMSRC_SEL_W-1:0];
        `TMSRC_OFS_STOP:  next_stop  = hwdata[`TMSRC_SEL_W-1:0];
        `TMSRC_OFS_CLEAR: next_clear = hwdata[`TMSRC_SEL_W-1:0];
        default:          next_start = sel_start;
      endcase
    end
    // read data is prepared during the address phase, so no wait state
    if (addr_ok && !hwrite) begin
      case (haddr)
        `TMSRC_OFS_START:  next_rdata = {16'h0000, sel_start};
        `TMSRC_OFS_STOP:   next_rdata = {16'h0000, sel_stop};
        `TMSRC_OFS_CLEAR:  next_rdata = {16'h0000, sel_clear};
        `TMSRC_OFS_COUNT:  next_rdata = 32'(count_value);
        `TMSRC_OFS_STATUS: next_rdata = {31'h00000000, count_running};
        default:           next_rdata = 32'h00000000;
      endcase
    end
  end

  // bus registers; hreadyout and hresp held at ready and OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_start <= `TMSRC_SEL_RESET;
      sel_stop  <= `TMSRC_SEL_RESET;
      sel_clear <= `TMSRC_SEL_RESET;
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      sel_start <= next_start;
      sel_stop  <= next_stop;
      sel_clear <= next_clear;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_rdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // counter control
  // run state and count follow the three decoded events
  logic             start_evt;   // some selected start source fired
  logic             stop_evt;    // some selected stop source fired
  logic             clear_evt;   // some selected clear source fired
  tmsrc_run_e       run;
  tmsrc_run_e       next_run;
  logic [CNT_W-1:0] next_count;
  logic             next_running;

  assign start_evt = sel_hit(sel_start, edges);
  assign stop_evt  = sel_hit(sel_stop, edges);
  assign clear_evt = sel_hit(sel_clear, edges);

  // stop beats start in the same cycle so a noisy pin cannot restart it;
  // clear beats counting so the cleared value is exactly zero
  always_comb begin
    next_run   = run;
    next_count = count_value;
    case (run)
      TMSRC_STOPPED: begin
        if (start_evt && !stop_evt) begin
          next_run = TMSRC_COUNTING;
        end
      end
      TMSRC_COUNTING: begin
        if (stop_evt) begin
          next_run = TMSRC_STOPPED;
        end
        next_count = count_value + 1'b1;
      end
      default: next_run = TMSRC_STOPPED;
    endcase
    if (clear_evt) begin
      next_count = '0;
    end
    next_running = (next_run == TMSRC_COUNTING);
  end

  // counter registers; count_running mirrors the state as a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run           <= TMSRC_STOPPED;
      count_value   <= '0;
      count_running <= 1'b0;
    end else begin
      run           <= next_run;
      count_value   <= next_count;
      count_running <= next_running;
    end
  end

  // checks
  // all on the bus clock and silent while reset is held
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // stable sample is the raw pin two edges earlier
  sync_delay_a: assert property (
    sync_stab == $past(raw_in, 2))
    else $error("synchroniser latency wrong");

  // single-cycle conditions shared by the start checks
  sequence trig0_rise_start;
    edges.rise[0] && sel_start[1:0] == 2'b01 && !stop_evt;
  endsequence
  sequence trig3_fall_start;
    edges.fall[3] && sel_start[7:6] == 2'b10 && !stop_evt;
  endsequence
  sequence pina_rise_blow;
    edges.rise[PA] && !edges.lvl[PB];
  endsequence
  sequence pinb_fall_ahigh;
    edges.fall[PB] && edges.lvl[PA];
  endsequence

  trig_rise_start_a: assert property (
    trig0_rise_start |=> count_running)
    else $error("trigger rise did not start counter");

  trig_fall_start_a: assert property (
    trig3_fall_start |=> count_running)
    else $error("trigger 3 fall did not start counter");

  pin_start_a: assert property (
    pina_rise_blow and (sel_start[9:8] == 2'b01 && !stop_evt)
      |=> count_running)
    else $error("pin a rise with b low did not start");

  pinb_start_a: assert property (
    pinb_fall_ahigh and (sel_start[15] && !stop_evt)
      |=> count_running)
    else $error("pin b fall with a high did not start");

  // any stop code with its rising bit set must halt on the next edge
  trig_stop_a: assert property (
    edges.rise[0] && sel_stop[0] |=> !count_running ##1 1)
    else $error("trigger rise did not stop counter");

  pin_stop_a: assert property (
    edges.rise[PA] && edges.lvl[PB] && sel_stop[9]
      |=> !count_running)
    else $error("pin a rise with b high did not stop");

  // clear lands one edge after the decoded event, running or not
  trig_clear_a: assert property (
    edges.fall[0] && sel_clear[1:0] == 2'b10 |=> count_value == '0)
    else $error("trigger fall did not clear counter");

  pin_clear_a: assert property (
    edges.rise[PA] && ((sel_clear[9] && edges.lvl[PB]) ||
                       (sel_clear[8] && !edges.lvl[PB]))
      |=> count_value == '0)
    else $error("pin a rise did not clear counter");

  no_source_a: assert property (
    sel_start == 16'h0000 && !count_running |=> !count_running)
    else $error("counter started with no source selected");

  // the sum is cut to the counter width, so a wrap at the top passes
  count_step_a: assert property (
    count_running && !clear_evt
      |=> count_value == $past(count_value) + 1'b1)
    else $error("running counter did not step by one");

endmodule

//--- tmsrc_pins_model.sv
// model of the external trigger and channel pins facing the timer
`timescale 1ns/1ns

module tmsrc_pins_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] want_trig,
  input  wire logic       want_a,
  input  wire logic       want_b,
  output logic      [3:0] external_trigger_input,
  output logic            channel_pin_a,
  output logic            channel_pin_b
);
  // pins move just after a clock edge, with no relation to the bus
  // traffic; the block must take them as plain asynchronous levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      external_trigger_input <= 4'h0;
      channel_pin_a          <= 1'b0;
      channel_pin_b          <= 1'b0;
    end else begin
      external_trigger_input <= want_trig;
      channel_pin_a          <= want_a;
      channel_pin_b          <= want_b;
    end
  end
endmodule

//--- tmsrc_top_tb.sv
// self-checking bench for the timer start, stop and clear source select
`timescale 1ns/1ns

module tmsrc_top_tb;
  import tmsrc_pkg::*;
  logic        hclk;       // bus and timer clock
  logic        hresetn;    // async reset, active low
  logic        hsel;       // slave select
  logic [7:0]  haddr;      // byte address
  logic [1:0]  htrans;     // transfer type
  logic [2:0]  hsize;      // transfer size, always a whole word
  logic        hwrite;     // write strobe
  logic [31:0] hwdata;     // write data
  logic [31:0] hrdata;     // read data
  logic        hreadyout;  // slave ready, fed back as hready
  logic        hresp;      // response, checked as OKAY
  logic [3:0]  w_trig;     // requested trigger levels
  logic        w_a;        // requested pin a level
  logic        w_b;        // requested pin b level
  logic [3:0]  trig;       // trigger wires
  logic        pin_a;      // pin a wire
  logic        pin_b;      // pin b wire
  logic [31:0] cnt;        // counter value
  logic        run;        // running flag
  logic [31:0] q;          // read result
  int          err_count;  // mismatches
  int          cmp_count;  // comparisons
  int          cycles;     // timeout counter

  tmsrc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_trigger_input(trig),
    .channel_pin_a(pin_a), .channel_pin_b(pin_b), .count_value(cnt),
    .count_running(run));

  tmsrc_pins_model PINS (.hclk(hclk), .hresetn(hresetn),
    .want_trig(w_trig), .want_a(w_a), .want_b(w_b),
    .external_trigger_input(trig), .channel_pin_a(pin_a),
    .channel_pin_b(pin_b));

  // free running clock, 8 ns period
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // cut a hang short; the whole run needs well under this
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single AHB-Lite transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  // move the pins, then give the sync and the counter time to react
  task automatic pins(input logic [3:0] t, input logic a, input logic b);
    @(posedge hclk);
    w_trig <= t;
    w_a    <= a;
    w_b    <= b;
    repeat (6) @(posedge hclk);
  endtask

  // selects keep 16 bits, upper half reads zero, unmapped reads zero
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hFFFFFFFF);
      xfer(1'b0, 8'(4 * i), 32'h0, q);
      chk(q, 32'h0000FFFF);
      chk(hresp, 1'b0);
      wr(8'(4 * i), 32'h0);
    end
    xfer(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h0);
  endtask

  // every trigger field, every edge code; pin a rise stops each time
  task automatic t_trig();
    logic [1:0] c;
    wr(8'h04, 32'h00000300);
    for (int i = 0; i < 4; i++) begin
      for (int k = 1; k < 4; k++) begin
        c = 2'(k);
        wr(8'h00, 32'(k) << (2 * i));
        pins(4'(1 << i), 1'b0, 1'b0);
        chk(run, c[0]);
        pins(4'(1 << i), 1'b1, 1'b0);
        pins(4'(1 << i), 1'b0, 1'b0);
        chk(run, 1'b0);
        pins(4'h0, 1'b0, 1'b0);
        chk(run, c[1]);
        pins(4'h0, 1'b1, 1'b0);
        pins(4'h0, 1'b0, 1'b0);
      end
    end
  endtask

  // pin a rise qualified by b, then the other three pin slots
  task automatic t_pin();
    logic [1:0] c;
    wr(8'h04, 32'h00000003);
    for (int k = 1; k < 4; k++) begin
      for (int b = 0; b < 2; b++) begin
        c = 2'(k);
        wr(8'h00, 32'(k) << 8);
        pins(4'h0, 1'b0, 1'(b));
        pins(4'h0, 1'b1, 1'(b));
        chk(run, (b == 1) ? c[1] : c[0]);
        pins(4'h1, 1'b0, 1'(b));
        pins(4'h0, 1'b0, 1'(b));
        chk(run, 1'b0);
      end
    end
    for (int s = 1; s < 4; s++) begin
      wr(8'h00, 32'h3 << (8 + 2 * s));
      pins(4'h0, s != 2, s == 3);
      pins(4'h0, s == 3, s == 2);
      chk(run, 1'b1);
      xfer(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h1);
      pins(4'h1, 1'b0, 1'b0);
      pins(4'h0, 1'b0, 1'b0);
    end
  endtask

  // clear works while stopped on a trigger fall, and while running on a qualified pin rise
  task automatic t_clear();
    wr(8'h04, 32'h00000300);
    wr(8'h00, 32'h00000001);
    pins(4'h1, 1'b0, 1'b0);
    repeat (20) @(posedge hclk);
    pins(4'h1, 1'b1, 1'b0);
    pins(4'h1, 1'b0, 1'b1);
    chk(32'(cnt == 32'h0), 32'h0);
    wr(8'h08, 32'h00000002);
    pins(4'h0, 1'b0, 1'b1);
    chk(cnt, 32'h0);
    xfer(1'b0, 8'h0C, 32'h0, q);
    chk(q, 32'h0);
    xfer(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    pins(4'h1, 1'b0, 1'b1);
    wr(8'h08, 32'h00000200);
    pins(4'h1, 1'b1, 1'b1);
    pins(4'h1, 1'b0, 1'b1);
    chk(cnt, 32'h0);
    pins(4'h0, 1'b0, 1'b0);
    pins(4'h1, 1'b0, 1'b0);
    pins(4'h1, 1'b1, 1'b0);
    chk(32'(cnt == 32'h0), 32'h0);
  endtask

  // reset, then the scenarios in turn
  initial begin
    hresetn <= 1'b0;
    hsel    <= 1'b0;
    haddr   <= 8'h00;
    htrans  <= 2'h0;
    hwrite  <= 1'b0;
    hsize   <= 3'h2;
    hwdata  <= 32'h0;
    w_trig  <= 4'h0;
    w_a     <= 1'b0;
    w_b     <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_trig();
    t_pin();
    t_clear();
    finish_test();
  end
endmodule
